/* logic/obcfg_pkg.sv */
// Purpose: Constants for the option byte configuration decoder
// Assumes: One 250 MHz clock, APB register access
// Notes: Offsets, field positions and the erased value live here; the option output reset value 6'h0A is set in obcfg_top
package obcfg_pkg;
  // Byte width and erased value
  localparam int OBCFG_W = 8;
  localparam logic [7:0] OBCFG_ERASED = 8'hFF;
  // Field positions in the option byte
  localparam int OBCFG_BIT_WDG = 5;
  localparam int OBCFG_BIT_NESTED_IRQ_OPTION = 4;
  localparam int OBCFG_BIT_LVD = 3;
  localparam int OBCFG_BIT_OSC = 1;
  localparam int OBCFG_BIT_RDP = 0;
  // Mask of bits that select a function (7, 6 and 2 are reserved)
  localparam logic [7:0] OBCFG_USED_MASK = 8'h3B;
  // APB register byte addresses
  localparam logic [7:0] OBCFG_ADDR_STATUS = 8'h00;
  localparam logic [7:0] OBCFG_ADDR_PROG = 8'h04;
  localparam logic [7:0] OBCFG_ADDR_CTRL = 8'h08;
  // Control register fields
  localparam int OBCFG_CTRL_PGM = 0;
  localparam int OBCFG_CTRL_ERASE = 1;
  // Status register fields above the byte
  localparam int OBCFG_ST_PGM = 8;
  localparam int OBCFG_ST_WIPE = 9;
  localparam int OBCFG_ST_BUSY = 10;
  // Duration of the whole-memory wipe, in cycles
  localparam int OBCFG_WIPE_CYCLES = 16;
  localparam logic [31:0] OBCFG_ZERO32 = 32'h0000_0000;
endpackage

/* logic/obcfg_decode.sv */
// Purpose: Splits a latched option byte into named option flags
// Assumes: Input byte is stable; output is pure decode
// Notes: Reserved bits are ignored
module obcfg_decode
  import obcfg_pkg::*;
(
  input wire logic [7:0] opt_byte,
  output logic watchdog_type_select,
  output logic nested_irq_option,
  output logic low_voltage_detect_off,
  output logic crystal_freq_select,
  output logic readout_protect_n
);
  // Each option is one bit at a fixed position
  always_comb begin
    watchdog_type_select = opt_byte[OBCFG_BIT_WDG];
    nested_irq_option = opt_byte[OBCFG_BIT_NESTED_IRQ_OPTION];
    low_voltage_detect_off = opt_byte[OBCFG_BIT_LVD];
    crystal_freq_select = opt_byte[OBCFG_BIT_OSC];
    readout_protect_n = opt_byte[OBCFG_BIT_RDP];
  end
endmodule

/* logic/obcfg_top.sv */
// Purpose: Option byte store, programming port and decoded option flags
// Assumes: APB master is the programming tool path; pins synchronous to pclk
// Notes: The byte is only reachable while programming mode is entered
import obcfg_pkg::*;

module obcfg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic watchdog_hw_en,
  output logic nested_irq_en,
  output logic lvd_en,
  output logic usb_clk_div2,
  output logic readout_block,
  output logic flash_write_block,
  output logic mem_wipe_req
);
  import obcfg_pkg::*;

  // Wipe sequencing states
  typedef enum logic [1:0] {OBCFG_IDLE, OBCFG_WIPE, OBCFG_CLR} obcfg_st_t;

  // All state of the block except the nonvolatile byte
  typedef struct packed {
    logic [7:0] lat;         // Copy captured just after reset release
    logic cap_done;          // Capture performed since reset
    logic pgm;               // Programming mode entered
    obcfg_st_t st;           // Wipe sequence state
    logic [7:0] wcnt;        // Wipe cycle counter
    logic [31:0] rdata;      // Registered read data
    logic ready;             // Access-phase answer
    logic err;               // Error answer
    logic [5:0] outs;        // Registered option outputs
    logic wipe;              // Wipe request output
  } obcfg_state_t;

  obcfg_state_t s_q;
  obcfg_state_t s_d;

  // Nonvolatile option byte, outside the reset struct so presetn leaves it alone
  // Power-up content is the erased value
  logic [7:0] nv_q = OBCFG_ERASED;
  logic [7:0] nv_d;

  // Decoded fields of the latched byte
  logic dec_wdg;
  logic dec_nested_irq_option;
  logic dec_lvd_off;
  logic dec_osc;
  logic dec_rdp_n;

  obcfg_decode u_dec (
    .opt_byte(s_q.lat),
    .watchdog_type_select(dec_wdg),
    .nested_irq_option(dec_nested_irq_option),
    .low_voltage_detect_off(dec_lvd_off),
    .crystal_freq_select(dec_osc),
    .readout_protect_n(dec_rdp_n)
  );

  // Access phase test, shared by reads and writes
  function automatic logic apb_access(input logic sel, input logic en, input logic rdy);
    apb_access = sel & en & ~rdy;
  endfunction

  logic acc;
  logic wr_ok;
  logic [7:0] wbyte;

  // Next-state logic
  always_comb begin
    s_d = s_q;
    nv_d = nv_q;
    acc = apb_access(psel, penable, s_q.ready);
    wr_ok = 1'b0;
    wbyte = pwdata[7:0];
    s_d.ready = 1'b0;
    s_d.err = 1'b0;
    // Capture the stored byte once, right after reset release
    if (!s_q.cap_done) begin
      s_d.lat = nv_q;
      s_d.cap_done = 1'b1;
    end
    // APB slave: answer every access after one wait cycle
    if (acc) begin
      s_d.ready = 1'b1;
      if (paddr == OBCFG_ADDR_STATUS) begin
        // Option byte hidden outside programming mode
        s_d.rdata = OBCFG_ZERO32;
        s_d.rdata[OBCFG_ST_PGM] = s_q.pgm;
        s_d.rdata[OBCFG_ST_WIPE] = s_q.st != OBCFG_IDLE;
        if (s_q.pgm) begin
          s_d.rdata[7:0] = nv_q;
        end
        if (pwrite) begin
          s_d.err = 1'b1;
        end
      end else if (paddr == OBCFG_ADDR_PROG) begin
        // Byte programming, only in programming mode and not wiping
        s_d.rdata = OBCFG_ZERO32;
        if (!s_q.pgm || s_q.st != OBCFG_IDLE) begin
          s_d.err = 1'b1;
        end else if (pwrite && pstrb[0]) begin
          wr_ok = 1'b1;
        end
      end else if (paddr == OBCFG_ADDR_CTRL) begin
        s_d.rdata = OBCFG_ZERO32;
        s_d.rdata[OBCFG_CTRL_PGM] = s_q.pgm;
        if (pwrite && pstrb[0]) begin
          s_d.pgm = pwdata[OBCFG_CTRL_PGM];
          // Erase the byte back to all ones
          if (pwdata[OBCFG_CTRL_ERASE] && s_q.pgm && s_q.st == OBCFG_IDLE) begin
            if (!nv_q[OBCFG_BIT_RDP]) begin
              s_d.st = OBCFG_WIPE;
              s_d.wcnt = 8'h00;
            end else begin
              nv_d = OBCFG_ERASED;
            end
          end
        end
      end else begin
        // Unmapped address
        s_d.rdata = OBCFG_ZERO32;
        s_d.err = 1'b1;
      end
    end
    // Programming clears bits only, like flash
    if (wr_ok) begin
      nv_d = nv_q & wbyte;
    end
    // Wipe sequence: memory first, then the byte
    case (s_q.st)
      OBCFG_WIPE: begin
        s_d.wcnt = s_q.wcnt + 8'h01;
        if (s_q.wcnt == 8'(OBCFG_WIPE_CYCLES - 1)) begin
          s_d.st = OBCFG_CLR;
        end
      end
      OBCFG_CLR: begin
        nv_d = OBCFG_ERASED;
        s_d.st = OBCFG_IDLE;
      end
      OBCFG_IDLE: begin
        // Stay put: an erase request above may have started a wipe
      end
      default: begin
        s_d.st = OBCFG_IDLE;
      end
    endcase
    s_d.wipe = s_d.st == OBCFG_WIPE;
    // Option outputs from the latched copy only; reserved bits unused
    s_d.outs[0] = ~dec_wdg;
    s_d.outs[1] = dec_nested_irq_option;
    s_d.outs[2] = ~dec_lvd_off;
    s_d.outs[3] = dec_osc;
    s_d.outs[4] = ~dec_rdp_n;
    s_d.outs[5] = ~dec_rdp_n;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.lat <= OBCFG_ERASED;
      s_q.cap_done <= 1'b0;
      s_q.pgm <= 1'b0;
      s_q.st <= OBCFG_IDLE;
      s_q.wcnt <= 8'h00;
      s_q.rdata <= OBCFG_ZERO32;
      s_q.ready <= 1'b0;
      s_q.err <= 1'b0;
      s_q.outs <= 6'h0A;
      s_q.wipe <= 1'b0;
    end else begin
      s_q.lat <= s_d.lat;
      s_q.cap_done <= s_d.cap_done;
      s_q.pgm <= s_d.pgm;
      s_q.st <= s_d.st;
      s_q.wcnt <= s_d.wcnt;
      s_q.rdata <= s_d.rdata;
      s_q.ready <= s_d.ready;
      s_q.err <= s_d.err;
      s_q.outs <= s_d.outs;
      s_q.wipe <= s_d.wipe;
    end
  end

  // Nonvolatile cell: no reset term, so its content survives presetn
  always_ff @(posedge pclk) begin
    nv_q <= nv_d;
  end

  // Outputs straight from flip-flops
  always_comb begin
    prdata = s_q.rdata;
    pready = s_q.ready;
    pslverr = s_q.err;
    watchdog_hw_en = s_q.outs[0];
    nested_irq_en = s_q.outs[1];
    lvd_en = s_q.outs[2];
    usb_clk_div2 = s_q.outs[3];
    readout_block = s_q.outs[4];
    flash_write_block = s_q.outs[5];
    mem_wipe_req = s_q.wipe;
  end

  // Latched copy only changes at the capture after reset
  a_latch_steady: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.cap_done && $past(s_q.cap_done) |-> $stable(s_q.lat))
    else $error("latched option byte changed during operation");
  // Outside programming mode the byte is never shown
  a_hidden_byte: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !s_q.pgm && $past(paddr) == OBCFG_ADDR_STATUS |-> prdata[7:0] == 8'h00)
    else $error("option byte visible outside programming mode");
  // Watchdog output follows bit 5
  a_wdg_map: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.cap_done |=> watchdog_hw_en == !$past(s_q.lat[OBCFG_BIT_WDG]))
    else $error("watchdog option wrong");
  // Nesting output follows bit 4
  a_nested_irq_option_map: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.cap_done |=> nested_irq_en == $past(s_q.lat[OBCFG_BIT_NESTED_IRQ_OPTION]))
    else $error("nesting option wrong");
  // LOW_VOLTAGE_DETECT_OFF output follows bit 3
  a_lvd_map: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.cap_done |=> lvd_en == !$past(s_q.lat[OBCFG_BIT_LVD]))
    else $error("low voltage option wrong");
  // Divider output follows bit 1
  a_osc_map: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.cap_done |=> usb_clk_div2 == $past(s_q.lat[OBCFG_BIT_OSC]))
    else $error("oscillator option wrong");
  // Protection outputs follow bit 0
  a_rdp_map: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.cap_done |=> readout_block == !$past(s_q.lat[OBCFG_BIT_RDP]) && flash_write_block == readout_block)
    else $error("readout protection option wrong");
  // Protected erase wipes memory before the byte clears
  sequence s_wipe_run;
    mem_wipe_req [*8];
  endsequence
  a_wipe_first: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(mem_wipe_req) |-> s_wipe_run ##[1:20] (!mem_wipe_req && nv_q == OBCFG_ERASED))
    else $error("wipe sequence wrong");
  // Reserved bits never alter outputs
  a_reserved_bits: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(s_q.lat & OBCFG_USED_MASK) ##1 1'b1 |-> $stable(s_q.outs))
    else $error("reserved bit changed an option");
endmodule

/* verification/obcfg_tool_model.sv */
// Purpose: Programming tool model reaching the option byte over APB
// Assumes: xfer is entered just after a rising edge of pclk
// Notes: No wait limit here; the bench timeout cuts a hang
module obcfg_tool_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bus idle at time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = {3'h0, 8'h00, 32'h0000_0000, 4'hF};
  end
  // One transfer: setup, access until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until pready is seen high at a rising edge
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // Release at that same edge; released lines no longer show the last value
    {psel, penable} <= 2'b00;
    paddr <= ~a;
    pwdata <= ~wd;
    @(posedge pclk);
  endtask
endmodule

/* verification/test_option_byte_config_decode.sv */
// Purpose: Self-checking bench for the option byte store and decode
// Assumes: Stored byte starts erased and survives presetn
// Notes: Expected flags are worked out from the byte value here
module test_option_byte_config_decode import obcfg_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic watchdog_hw_en, nested_irq_en, lvd_en, usb_clk_div2;
  logic readout_block, flash_write_block, mem_wipe_req;
  int n_mismatch = 0, comparisons = 0, cycles = 0, wipe_cnt = 0;
  obcfg_top obcfg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdog_hw_en(watchdog_hw_en),
    .nested_irq_en(nested_irq_en), .lvd_en(lvd_en), .usb_clk_div2(usb_clk_div2),
    .readout_block(readout_block), .flash_write_block(flash_write_block),
    .mem_wipe_req(mem_wipe_req));
  obcfg_tool_model obcfg_tool_model_inst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // Clock at 250 MHz
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;
  // Cycles of wipe request, seen mid-cycle
  always @(negedge pclk) if (mem_wipe_req === 1'b1) wipe_cnt++;
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus access with expected error response
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      input logic exp_err);
    logic err;
    obcfg_tool_model_inst.xfer(wr, a, wd, rd, err);
    check({31'h0, err}, {31'h0, exp_err});
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // Flags decoded from byte b: bits 5, 3, 0 active low, 4 and 1 active high
  task automatic check_opts(input logic [7:0] b);
    @(negedge pclk);
    check({26'h0, watchdog_hw_en, nested_irq_en, lvd_en, usb_clk_div2, readout_block,
      flash_write_block}, {26'h0, ~b[5], b[4], ~b[3], b[1], ~b[0], ~b[0]});
    @(posedge pclk);
  endtask
  task automatic test_access;
    check_opts(OBCFG_ERASED);
    acc(1'b0, OBCFG_ADDR_STATUS, 32'h0, 1'b0);
    check(rd, 32'h0000_0000);
    acc(1'b1, OBCFG_ADDR_PROG, 32'h0, 1'b1);
    acc(1'b0, OBCFG_ADDR_PROG, 32'h0, 1'b1);
    acc(1'b1, OBCFG_ADDR_STATUS, 32'h0, 1'b1);
    acc(1'b0, 8'h0C, 32'h0, 1'b1);
    acc(1'b1, OBCFG_ADDR_CTRL, 32'h1, 1'b0);
    acc(1'b0, OBCFG_ADDR_STATUS, 32'h0, 1'b0);
    check(rd, 32'h0000_01FF);
    $display("test_access done");
  endtask
  task automatic test_reserved;
    acc(1'b1, OBCFG_ADDR_PROG, 32'h3B, 1'b0);
    acc(1'b0, OBCFG_ADDR_STATUS, 32'h0, 1'b0);
    check(rd, 32'h0000_013B);
    do_reset();
    check_opts(OBCFG_ERASED);
    acc(1'b1, OBCFG_ADDR_CTRL, 32'h1, 1'b0);
    wipe_cnt = 0;
    acc(1'b1, OBCFG_ADDR_CTRL, 32'h3, 1'b0);
    acc(1'b0, OBCFG_ADDR_STATUS, 32'h0, 1'b0);
    check(rd, 32'h0000_01FF);
    check(wipe_cnt, 32'h0);
    $display("test_reserved done");
  endtask
  task automatic test_program;
    acc(1'b1, OBCFG_ADDR_PROG, 32'h0, 1'b0);
    acc(1'b0, OBCFG_ADDR_PROG, 32'h0, 1'b0);
    check(rd, 32'h0000_0000);
    check_opts(OBCFG_ERASED);
    do_reset();
    check_opts(8'h00);
    $display("test_program done");
  endtask
  task automatic test_wipe;
    acc(1'b1, OBCFG_ADDR_CTRL, 32'h1, 1'b0);
    wipe_cnt = 0;
    acc(1'b1, OBCFG_ADDR_CTRL, 32'h3, 1'b0);
    acc(1'b0, OBCFG_ADDR_STATUS, 32'h0, 1'b0);
    check({31'h0, rd[OBCFG_ST_WIPE]}, 32'h1);
    acc(1'b1, OBCFG_ADDR_PROG, 32'h0, 1'b1);
    repeat (24) @(posedge pclk);
    check(wipe_cnt, OBCFG_WIPE_CYCLES);
    acc(1'b0, OBCFG_ADDR_STATUS, 32'h0, 1'b0);
    check(rd, 32'h0000_01FF);
    check_opts(8'h00);
    do_reset();
    check_opts(OBCFG_ERASED);
    $display("test_wipe done");
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    presetn = 1'b0;
    do_reset();
    test_access();
    test_reserved();
    test_program();
    test_wipe();
    finish_test();
  end
endmodule
